// ===== bench/edsq_ladder_model.sv
// Model of the controlling ladder program: scan strobe and event points
`timescale 1ns/100ps
module edsq_ladder_model #(
  parameter int SCAN_CYC = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] event_req_i,
  output logic             scan_o,
  output logic      [15:0] event_o
);
  logic [7:0] cnt_ff;
  logic       wrap;

  assign wrap = (cnt_ff == 8'(SCAN_CYC - 1));

  // ****************************************
  // Scan strobe
  // ****************************************
  // One pulse per scan period, never back to back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 8'h00;
      scan_o <= 1'b0;
    end else begin
      cnt_ff <= wrap ? 8'h00 : cnt_ff + 8'h01;
      scan_o <= wrap;
    end
  end

  // ****************************************
  // Event points
  // ****************************************
  // Points move only mid-scan, as ladder outputs would
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_o <= 16'h0000;
    end else if (cnt_ff == 8'h01) begin
      event_o <= event_req_i;
    end
  end
endmodule // edsq_ladder_model

// ===== bench/testbench.sv
// Self-checking testbench for the event drum sequencer
`timescale 1ns/100ps
module testbench;
  import edsq_pkg::*;
  localparam int TICK = 10;
  localparam int SCAN = 4;
  localparam int TB   = 3;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } edsq_row_t;

  logic        clk = 1'b0;
  logic        rst_n;
  logic        scan;
  logic [15:0] ev_req;
  logic [15:0] events;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [15:0] drum_out;
  logic        complete;
  logic [31:0] d;
  int          n;
  int          num_errors = 0;
  int          checked = 0;

  // Reset values, clamps, write-only and unmapped places
  edsq_row_t rows [20] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h1},
    '{1'b0, 8'h08, 32'h0, 32'h1}, '{1'b0, 8'h0c, 32'h0, 32'h10},
    '{1'b0, 8'h10, 32'h0, 32'hffff}, '{1'b0, 8'h14, 32'h0, 32'h0},
    '{1'b0, 8'h18, 32'h0, 32'h0}, '{1'b0, 8'h1c, 32'h0, 32'h1},
    '{1'b0, 8'h20, 32'h0, 32'h1}, '{1'b0, 8'h24, 32'h0, 32'h0},
    '{1'b1, 8'h40, 32'h5a5a, 32'h0}, '{1'b1, 8'h80, 32'h4003, 32'h0},
    '{1'b1, 8'hfc, 32'h1234, 32'h0}, '{1'b1, 8'h04, 32'h0, 32'h1},
    '{1'b1, 8'h04, 32'h270f, 32'h270f}, '{1'b1, 8'h04, 32'h2710, 32'h270f},
    '{1'b1, 8'h0c, 32'h0, 32'h1}, '{1'b1, 8'h0c, 32'h11, 32'h10},
    '{1'b1, 8'h1c, 32'h2, 32'h2}, '{1'b1, 8'h24, 32'h3f, 32'h3f}};

  always #5 clk = ~clk;

  edsq_ladder_model #(.SCAN_CYC(SCAN)) partner (.clk_i(clk), .rst_n_i(rst_n),
    .event_req_i(ev_req), .scan_o(scan), .event_o(events));

  edsq_event_drum_sequencer #(.TICK_CYC(TICK)) DUT (.CLK_I(clk),
    .RSTN_I(rst_n), .SCAN_I(scan), .EVENT_I(events), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .DRUM_OUT_O(drum_out), .COMPLETE_O(complete));

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [15:0] pat(input int i);
    return {4{4'(i)}};
  endfunction

  task automatic check_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_out(input string nm, input logic [15:0] e);
    checked++;
    if (drum_out !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, drum_out);
    end
  endtask

  // Both tasks start and end just after a rising edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Data are sampled at the edge that closes their only valid cycle
  task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  task automatic wait_out(input string nm, input logic [15:0] e,
                          input int bound);
    for (int i = 0; i < bound && drum_out !== e; i++) @(posedge clk);
    check_out(nm, e);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    idle(20000);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    ev_req = 16'h0;
    idle(4);
    rst_n <= 1'b1;
    idle(3);
    check_out("out_rst", 16'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) bus_write(rows[i].addr, rows[i].wdata);
      bus_read(rows[i].addr, d);
      check_word("reg", rows[i].exp, d);
    end
    for (int i = 1; i <= 4; i++) bus_write(8'(8'h3c + 4 * i), 32'(pat(i)));
    bus_write(8'h80, 32'h0003_8000);
    bus_write(8'h84, 32'h0000_4002);
    bus_write(8'h88, 32'h0005_c001);
    bus_write(8'h8c, 32'h0);
    bus_write(8'h04, TB);
    bus_write(8'h0c, 32'h4);
    bus_write(8'h08, 32'h1);
    // Start and a true event while held in reset
    ev_req <= 16'h0008;
    bus_write(8'h00, 32'h3);
    wait_out("held_pre", pat(1), 40);
    idle(40);
    check_out("held", pat(1));
    ev_req <= 16'h0000;
    // Let the event point settle before the hold lifts
    idle(8);
    bus_write(8'h00, 32'h1);
    idle(40);
    check_out("ev_wait", pat(1));
    ev_req <= 16'h0008;
    wait_out("ev_step", pat(2), 40);
    n = 0;
    while (drum_out === pat(2) && n < 500) begin
      @(posedge clk);
      n++;
    end
    // Dwell is within one tick plus two scans of the formula
    check_word("dwell", 1, 32'(n >= 2*TB*TICK - TICK &&
                              n <= 2*TB*TICK + TICK + 2*SCAN));
    check_out("no_mid", pat(3));
    idle(60);
    bus_read(8'h14, d);
    check_word("cnt_frozen", 32'h0, d);
    ev_req <= 16'h0020;
    wait_out("comb_step", pat(4), 200);
    for (int i = 0; i < 40 && complete !== 1'b1; i++) @(posedge clk);
    check_word("complete", 32'h1, 32'(complete));
    bus_read(8'h14, d);
    check_word("slot_done", 32'h1, 32'(d[16]));
    bus_write(8'h00, 32'h5);
    idle(20);
    bus_write(8'h00, 32'h1);
    idle(20);
    check_out("done_hold", pat(4));
    bus_read(8'h20, d);
    check_word("done_step", 32'h4, d);
    bus_write(8'h00, 32'h2);
    wait_out("rst_step", pat(1), 40);
    idle(2);
    check_word("complete_clr", 32'h0, 32'(complete));
    bus_write(8'h00, 32'h0);
    ev_req <= 16'h0008;
    idle(60);
    check_out("frozen", pat(1));
    bus_write(8'h00, 32'h4);
    bus_write(8'h00, 32'h0);
    wait_out("jog", pat(2), 40);
    bus_read(8'h20, d);
    check_word("jog_step", 32'h2, d);
    bus_read(8'h18, d);
    check_word("timer_clr", 32'h0, d);
    bus_write(8'h08, 32'h3);
    bus_write(8'h00, 32'h8);
    wait_out("jump", pat(3), 40);
    bus_read(8'h20, d);
    check_word("jump_step", 32'h3, d);
    // Masked outputs show only after the next step entry
    bus_write(8'h10, 32'h00ff);
    bus_write(8'h00, 32'h2);
    wait_out("mask", 16'h0033, 40);
    bus_write(8'h00, 32'h0);
    // Pin reset mid-run drops outputs and settings at once
    rst_n <= 1'b0;
    idle(2);
    check_out("out_arst", 16'h0);
    rst_n <= 1'b1;
    idle(3);
    bus_read(8'h04, d);
    check_word("tb_arst", 32'h1, d);
    bus_read(8'h20, d);
    check_word("step_arst", 32'h1, d);
    tally_and_finish();
  end
endmodule // testbench

// ===== verilog/edsq_event_drum_sequencer.sv
// Event drum sequencer: register port, step engine and timers
// What this block does
// - Sixteen steps, each with sixteen-bit pattern
// - One output assignment shared by all steps
// - Output column n is word bit n
// - Step pattern reaches outputs two cycles after step entry
// - One common timebase, 0.01 s to 99.99 s
// - Dwell equals 0.01 s times timebase times count
// - Timebase and step count accept up to 9999
// - Elapsed count advances to next step
// - Event step waits while its input false
// - Combined step times only while event true
// - Per-step event, time or combined condition
// - Fewer steps and outputs are allowed
// - Four consecutive counter slots at fixed offsets 0x14 to 0x20; slot base is only stored
// - First slot bit: set done, cleared reset
// - Evaluated once per scan only
// - Jump straight to preset step on command
// - Reset overrides start, holds preset step
// - Start off freezes timer, step and outputs
// - Jog rising edge advances one step
// - Complete state holds outputs until reset
`timescale 1ns/100ps
module edsq_event_drum_sequencer #(
  parameter int TICK_CYC = edsq_pkg::TICK_CYCLES
) (
  input  wire logic                        CLK_I,
  input  wire logic                        RSTN_I,
  input  wire logic                        SCAN_I,
  input  wire logic [edsq_pkg::OUT_W-1:0]  EVENT_I,
  input  wire logic [7:0]                  ADDR_I,
  input  wire logic [31:0]                 WDATA_I,
  input  wire logic                        WR_I,
  input  wire logic                        RD_I,
  output logic      [31:0]                 RDATA_O,
  output logic      [edsq_pkg::OUT_W-1:0]  DRUM_OUT_O,
  output logic                             COMPLETE_O
);
  import edsq_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic              start_ff, hold_ff, jog_ff;
  logic [VAL_W-1:0]  timebase_ff;
  logic [STEP_W-1:0] preset_ff, last_ff;
  logic [OUT_W-1:0]  mask_ff;
  logic [5:0]        slotbase_ff;
  logic              jump_set, jog_set;
  logic              pat_we, cfg_we;
  logic [VAL_W-1:0]  wr_val;
  logic [STEP_W-1:0] wr_step;
  always_comb begin
    wr_val  = (WDATA_I[31:VAL_W] != '0 || WDATA_I[VAL_W-1:0] > VAL_MAX)
              ? VAL_MAX : WDATA_I[VAL_W-1:0];
    wr_step = (WDATA_I[31:STEP_W] != '0 || WDATA_I[STEP_W-1:0] > STEP_MAX)
              ? STEP_MAX : WDATA_I[STEP_W-1:0];
    if (wr_step < STEP_MIN) begin
      wr_step = STEP_MIN;
    end
  end
  assign jump_set = WR_I && ADDR_I == OFS_CTRL && WDATA_I[CTRL_JUMP];
  assign jog_set  = WR_I && ADDR_I == OFS_CTRL && WDATA_I[CTRL_JOG]
                    && !jog_ff && !WDATA_I[CTRL_RESET];
  assign pat_we   = WR_I && ADDR_I[7:6] == SEL_PATTERN && ADDR_I[1:0] == 2'h0;
  assign cfg_we   = WR_I && ADDR_I[7:6] == SEL_CONFIG && ADDR_I[1:0] == 2'h0;
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      start_ff    <= 1'b0;
      hold_ff     <= 1'b0;
      jog_ff      <= 1'b0;
      timebase_ff <= TIMEBASE_RST;
      preset_ff   <= PRESET_RST;
      last_ff     <= LAST_RST;
      mask_ff     <= OUTMASK_RST;
      slotbase_ff <= SLOTBASE_RST;
    end else if (WR_I) begin
      case (ADDR_I)
        OFS_CTRL: begin
          start_ff <= WDATA_I[CTRL_START];
          hold_ff  <= WDATA_I[CTRL_RESET];
          jog_ff   <= WDATA_I[CTRL_JOG];
        end
        OFS_TIMEBASE: begin
          timebase_ff <= (wr_val == '0) ? TIMEBASE_RST : wr_val;
        end
        OFS_PRESET:   preset_ff   <= wr_step;
        OFS_SLOT2:    preset_ff   <= wr_step;
        OFS_LAST:     last_ff     <= wr_step;
        OFS_OUTMASK:  mask_ff     <= WDATA_I[OUT_W-1:0];
        OFS_SLOTBASE: slotbase_ff <= WDATA_I[5:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Step store
  // ****************************************
  logic [STEP_W-1:0] cur_ff;
  logic [OUT_W-1:0]  pat_q;
  logic [CFG_W-1:0]  cfg_q, cfg_wdata;
  logic [3:0]        rd_idx;
  assign rd_idx    = 4'(cur_ff - STEP_MIN);
  // Flag bits sit above the count, so only the count field is clamped
  assign cfg_wdata = {WDATA_I[19:CFG_TIME], (WDATA_I[VAL_W-1:0] > VAL_MAX)
                      ? VAL_MAX : WDATA_I[VAL_W-1:0]};
  edsq_step_mem #(.W(OUT_W)) u_pattern (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n_ff),
    .we_i    (pat_we),
    .waddr_i (ADDR_I[5:2]),
    .wdata_i (WDATA_I[OUT_W-1:0]),
    .raddr_i (rd_idx),
    .rdata_o (pat_q)
  );
  edsq_step_mem #(.W(CFG_W)) u_config (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n_ff),
    .we_i    (cfg_we),
    .waddr_i (ADDR_I[5:2]),
    .wdata_i (cfg_wdata),
    .raddr_i (rd_idx),
    .rdata_o (cfg_q)
  );

  // ****************************************
  // Scan, tick and command latches
  // ****************************************
  edsq_state_t      state_ff;
  logic             scan_ff, tick_ff, jogp_ff, jump_ff;
  logic [31:0]      pre_ff;
  logic             consume;
  // Sub-scan ticks collapse into one, so timing is scan-limited
  assign consume = scan_ff && (state_ff == ST_RUN || state_ff == ST_DONE);
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff  <= (pre_ff >= 32'(TICK_CYC - 1)) ? '0 : pre_ff + 32'd1;
      tick_ff <= (pre_ff >= 32'(TICK_CYC - 1)) | (tick_ff & !consume);
    end
  end
  // Set wins over consume on every latch
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scan_ff <= 1'b0;
      jogp_ff <= 1'b0;
      jump_ff <= 1'b0;
    end else begin
      scan_ff <= SCAN_I | (scan_ff & !consume);
      jogp_ff <= jog_set | (jogp_ff & !consume & !hold_ff);
      jump_ff <= jump_set | (jump_ff & !consume);
    end
  end

  // ****************************************
  // Step engine
  // ****************************************
  logic [VAL_W-1:0] count_ff, timer_ff;
  logic             done_ff;
  logic             use_t, use_e, ev, go_pre, adv, tstep;
  assign use_t = cfg_q[CFG_TIME];
  assign use_e = cfg_q[CFG_EVENT];
  assign ev    = EVENT_I[cfg_q[CFG_W-1:CFG_SEL_LO]];
  always_comb begin
    go_pre = 1'b0;
    adv    = 1'b0;
    tstep  = 1'b0;
    if (consume) begin
      if (hold_ff) begin
        go_pre = 1'b1;
      end else if (state_ff == ST_RUN) begin
        if (jogp_ff) begin
          adv = 1'b1;
        end else if (jump_ff) begin
          go_pre = 1'b1;
        end else if (start_ff) begin
          if (!use_t) begin
            adv = !use_e || ev;
          end else if (count_ff >= cfg_q[VAL_W-1:0]) begin
            adv = 1'b1;
          end else begin
            tstep = tick_ff && (!use_e || ev);
          end
        end
      end
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff   <= ST_LOAD;
      cur_ff     <= PRESET_RST;
      count_ff   <= '0;
      timer_ff   <= '0;
      done_ff    <= 1'b0;
      DRUM_OUT_O <= '0;
    end else begin
      case (state_ff)
        ST_LOAD: state_ff <= ST_FETCH;
        ST_FETCH: begin
          DRUM_OUT_O <= pat_q & mask_ff;
          state_ff   <= ST_RUN;
        end
        ST_RUN, ST_DONE: begin
          if (go_pre) begin
            cur_ff   <= preset_ff;
            count_ff <= '0;
            timer_ff <= '0;
            done_ff  <= 1'b0;
            state_ff <= ST_LOAD;
          end else if (adv && cur_ff >= last_ff) begin
            done_ff  <= 1'b1;
            state_ff <= ST_DONE;
          end else if (adv) begin
            cur_ff   <= STEP_W'(cur_ff + 5'd1);
            count_ff <= '0;
            timer_ff <= '0;
            state_ff <= ST_LOAD;
          end else if (tstep) begin
            if (timer_ff + 14'd1 >= timebase_ff) begin
              timer_ff <= '0;
              count_ff <= VAL_W'(count_ff + 14'd1);
            end else begin
              timer_ff <= VAL_W'(timer_ff + 14'd1);
            end
          end
        end
        default: state_ff <= ST_LOAD;
      endcase
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      COMPLETE_O <= 1'b0;
    end else begin
      COMPLETE_O <= done_ff;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      case (ADDR_I)
        OFS_CTRL:     RDATA_O <= {29'h0, jog_ff, hold_ff, start_ff};
        OFS_TIMEBASE: RDATA_O <= 32'(timebase_ff);
        OFS_PRESET:   RDATA_O <= 32'(preset_ff);
        OFS_LAST:     RDATA_O <= 32'(last_ff);
        OFS_OUTMASK:  RDATA_O <= 32'(mask_ff);
        OFS_SLOT0:    RDATA_O <= {15'h0, done_ff, 2'h0, count_ff};
        OFS_SLOT1:    RDATA_O <= 32'(timer_ff);
        OFS_SLOT2:    RDATA_O <= 32'(preset_ff);
        OFS_SLOT3:    RDATA_O <= 32'(cur_ff);
        OFS_SLOTBASE: RDATA_O <= 32'(slotbase_ff);
        default:      RDATA_O <= 32'h0;
      endcase
    end else begin
      RDATA_O <= 32'h0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_fetch_pattern:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      state_ff == ST_FETCH |=> DRUM_OUT_O == $past(pat_q & mask_ff))
    else $error("outputs did not take step pattern");
  a_reset_hold:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      consume && hold_ff |=> cur_ff == $past(preset_ff) && count_ff == '0
        ##1 state_ff == ST_FETCH ##1 state_ff == ST_RUN)
    else $error("reset did not hold preset step");
  a_freeze_stop:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      consume && state_ff == ST_RUN && !start_ff && !hold_ff
        && !jogp_ff && !jump_ff
      |=> $stable(cur_ff) && $stable(count_ff) && $stable(timer_ff)
        && $stable(DRUM_OUT_O))
    else $error("stopped drum moved");
  a_done_sticky:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      state_ff == ST_DONE && !(consume && hold_ff)
      |=> state_ff == ST_DONE && $stable(DRUM_OUT_O) && $stable(cur_ff))
    else $error("complete state left without reset");
  a_done_bit:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      done_ff == (state_ff == ST_DONE) ##1 COMPLETE_O == $past(done_ff))
    else $error("complete bit mismatch");
  a_entry_clear:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      state_ff == ST_LOAD |-> count_ff == '0 && timer_ff == '0)
    else $error("step entered with nonzero timer");
  a_event_gate:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      consume && state_ff == ST_RUN && start_ff && !hold_ff && !jogp_ff
        && !jump_ff && use_t && use_e && !ev && count_ff < cfg_q[VAL_W-1:0]
      |=> $stable(count_ff) && $stable(timer_ff) && $stable(cur_ff))
    else $error("timer ran without event");
  a_jog_advance:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      consume && state_ff == ST_RUN && !hold_ff && jogp_ff
        && cur_ff < last_ff
      |=> cur_ff == $past(cur_ff) + 5'd1 && state_ff == ST_LOAD)
    else $error("jog did not advance one step");
  a_jump_preset:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      go_pre |=> cur_ff == $past(preset_ff) && !done_ff)
    else $error("jump missed preset step");
  a_value_range:
    assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
      timebase_ff <= VAL_MAX && timebase_ff != '0
        && cur_ff >= STEP_MIN && cur_ff <= STEP_MAX)
    else $error("setting out of range");

endmodule // edsq_event_drum_sequencer

// ===== verilog/edsq_pkg.sv
// Constants and types shared by the event drum sequencer
package edsq_pkg;

  // ****************************************
  // Clock and timebase
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 10_000_000; // 0.01 s timebase unit
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int STEPS     = 16;
  localparam int OUT_W     = 16;
  localparam int VAL_W     = 14;
  localparam int STEP_W    = 5;
  localparam int CFG_W     = 20;
  localparam logic [VAL_W-1:0]  VAL_MAX   = 14'd9999;
  localparam logic [STEP_W-1:0] STEP_MIN  = 5'd1;
  localparam logic [STEP_W-1:0] STEP_MAX  = 5'd16;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TIMEBASE = 8'h04;
  localparam logic [7:0] OFS_PRESET   = 8'h08;
  localparam logic [7:0] OFS_LAST     = 8'h0c;
  localparam logic [7:0] OFS_OUTMASK  = 8'h10;
  localparam logic [7:0] OFS_SLOT0    = 8'h14;
  localparam logic [7:0] OFS_SLOT1    = 8'h18;
  localparam logic [7:0] OFS_SLOT2    = 8'h1c;
  localparam logic [7:0] OFS_SLOT3    = 8'h20;
  localparam logic [7:0] OFS_SLOTBASE = 8'h24;
  localparam logic [1:0] SEL_PATTERN  = 2'h1; // 0x40 + 4*(step-1)
  localparam logic [1:0] SEL_CONFIG   = 2'h2; // 0x80 + 4*(step-1)

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_START  = 0;
  localparam int CTRL_RESET  = 1;
  localparam int CTRL_JOG    = 2;
  localparam int CTRL_JUMP   = 3;
  localparam int SLOT0_DONE  = 16;
  localparam int CFG_TIME    = 14;
  localparam int CFG_EVENT   = 15;
  localparam int CFG_SEL_LO  = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [VAL_W-1:0]  TIMEBASE_RST = 14'd1;
  localparam logic [STEP_W-1:0] PRESET_RST   = 5'd1;
  localparam logic [STEP_W-1:0] LAST_RST     = 5'd16;
  localparam logic [OUT_W-1:0]  OUTMASK_RST  = 16'hffff;
  localparam logic [5:0]        SLOTBASE_RST = 6'h00;

  // ****************************************
  // Engine states
  // ****************************************
  typedef enum logic [1:0] {
    ST_LOAD  = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN   = 2'b11,
    ST_DONE  = 2'b10
  } edsq_state_t;

endpackage

// ===== verilog/edsq_step_mem.sv
// Sixteen-word step store with registered read data
`timescale 1ns/100ps
module edsq_step_mem #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         we_i,
  input  wire logic [3:0]   waddr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic [3:0]   raddr_i,
  output logic      [W-1:0] rdata_o
);
  import edsq_pkg::*;

  logic [W-1:0] mem_ff [STEPS];

  // Cleared at reset so a fresh drum drives all outputs off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STEPS; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_ff[raddr_i];
    end
  end

endmodule // edsq_step_mem
